// ===== design/hmic_top.sv
// Purpose: mode select, connect control, ref select and interrupt pin
// Assumes: serial port already decoded into addr/wdata/wr/rd strobes
// Notes:   Notes on behaviour
`timescale 1ns/1ps
module hmic_top
    import hmic_pkg::*;
#(
    parameter int N = EVENT_BITS
) (
    input  wire logic         CLK,            // 20 MHz system clock
    input  wire logic         RESET,          // sync reset, active high
    input  wire logic         MODE_RESET_N,   // mode pin, active low reset
    input  wire logic         MODE_BYPASS_N,  // mode pin, active low bypass
    input  wire logic         HUB_CONNECT,    // connect request input
    input  wire logic [1:0]   REF_SEL,        // reference clock select
    input  wire logic         REF_CLOCK_IN,   // reference clock, sampled
    input  wire logic         HUB_CONFIGURED, // hub configured by host
    input  wire logic         HUB_SUSPENDED,  // whole hub suspended
    input  wire logic         PORT_SUSPENDED, // selective port suspend
    input  wire logic [N-1:0] EVENT_COND,     // interrupt conditions
    input  wire logic [7:0]   SP_ADDR,        // serial register address
    input  wire logic [7:0]   SP_WDATA,       // serial write data
    input  wire logic         SP_WR,          // write strobe
    input  wire logic         SP_RD,          // read strobe
    output logic [7:0]        SP_RDATA,       // read data, registered
    output logic              INT_N_O,        // pin output value, always 0
    output logic              INT_N_OE_N,     // low while pulling pin low
    output logic              MODE_STANDBY,   // in standby
    output logic              MODE_BYPASS,    // in bypass, switch on
    output logic              MODE_HUB,       // full hub mode
    output logic              COMM_STAGE,     // communication stage entered
    output logic [1:0]        REF_SEL_LATCHED,// latched ref select
    output logic              REF_EDGE        // one-cycle ref rising edge
);
    hmic_evt_if #(.N(N)) evt ();

    hmic_mode_t   mode;
    hmic_stage_t  stage_reg, stage_next;
    logic [7:0]   mask_reg;
    logic [7:0]   ilock_reg;
    logic         susp_sel_reg;
    logic [7:0]   rdata_reg;
    logic [1:0]   refsel_reg;
    logic         ref_prev_reg;
    logic         conn_prev_reg;
    logic         hub_prev_reg;

    // mode decode from the two active-low pins
    wire mode_hub     = MODE_RESET_N & MODE_BYPASS_N;
    wire mode_bypass  = MODE_RESET_N & ~MODE_BYPASS_N;
    // reset low with either bypass level is standby
    wire mode_standby = ~MODE_RESET_N;
    assign mode = mode_hub ? HMIC_HUB :
                  (mode_bypass ? HMIC_BYPASS : HMIC_STANDBY);
    assign MODE_STANDBY = (mode == HMIC_STANDBY);
    assign MODE_BYPASS  = (mode == HMIC_BYPASS);
    assign MODE_HUB     = (mode == HMIC_HUB);

    // register decode
    wire wr_status = SP_WR & (SP_ADDR == EVENT_STATUS_ADDR) & mode_hub;
    wire wr_mask   = SP_WR & (SP_ADDR == EVENT_MASK_ADDR) & mode_hub;
    wire wr_ilock  = SP_WR & (SP_ADDR == ILOCK_ADDR) & mode_hub;
    wire hold_bit  = ilock_reg[ILOCK_CONNECT_BIT];

    // write one to clear status bits
    assign evt.cond = mode_hub ? EVENT_COND : '0;
    assign evt.clr  = wr_status ? SP_WDATA[N-1:0] : '0;

    hmic_event_latch #(.N(N)) u_latch (
        .clk   (CLK),
        .reset (RESET | ~mode_hub),
        .evt   (evt)
    );

    // reference clock: only its rising edges are used
    wire ref_rise = REF_CLOCK_IN & ~ref_prev_reg;
    assign REF_EDGE = ref_rise;

    // connect edge detect
    wire conn_rise = HUB_CONNECT & ~conn_prev_reg;
    wire hub_entry = mode_hub & ~hub_prev_reg;

    // communication stage sequencing
    always_comb begin
        stage_next = stage_reg;
        case (stage_reg)
            HMIC_ST_IDLE: begin
                if (mode_hub)
                    stage_next = HMIC_ST_WAIT;
            end
            HMIC_ST_WAIT: begin
                if (HUB_CONNECT)
                    stage_next = HMIC_ST_COMM;
                else if (conn_rise)
                    stage_next = HMIC_ST_COMM;
                else if (!hold_bit)
                    stage_next = HMIC_ST_COMM;
            end
            HMIC_ST_COMM: begin
                stage_next = HMIC_ST_COMM;
            end
            default: begin
                stage_next = HMIC_ST_IDLE;
            end
        endcase
        if (!mode_hub)
            stage_next = HMIC_ST_IDLE;
    end
    assign COMM_STAGE = (stage_reg == HMIC_ST_COMM);

    always_ff @(posedge CLK) begin
        if (RESET) begin
            stage_reg     <= HMIC_ST_IDLE;
            ref_prev_reg  <= 1'b0;
            conn_prev_reg <= 1'b0;
            hub_prev_reg  <= 1'b0;
        end else begin
            stage_reg     <= stage_next;
            ref_prev_reg  <= REF_CLOCK_IN;
            conn_prev_reg <= HUB_CONNECT;
            hub_prev_reg  <= mode_hub;
        end
    end

    // configuration registers; lost outside hub mode
    always_ff @(posedge CLK) begin
        if (RESET || !mode_hub) begin
            mask_reg     <= EVENT_MASK_RST;
            ilock_reg    <= ILOCK_RST;
            susp_sel_reg <= 1'b0;
        end else begin
            if (wr_mask)
                mask_reg <= SP_WDATA;
            if (wr_ilock) begin
                ilock_reg    <= SP_WDATA;
                susp_sel_reg <= SP_WDATA[7];
            end
        end
    end

    // ref select latched on entry to hub mode
    always_ff @(posedge CLK) begin
        if (RESET)
            refsel_reg <= REFSEL_38M4;
        else if (hub_entry)
            refsel_reg <= REF_SEL;
    end
    assign REF_SEL_LATCHED = refsel_reg;

    // register read mux
    wire [7:0] status_word = {{(8-N){1'b0}}, evt.status};
    wire [7:0] rd_mux =
        (SP_ADDR == EVENT_STATUS_ADDR) ? status_word :
        (SP_ADDR == EVENT_MASK_ADDR)   ? mask_reg :
        (SP_ADDR == ILOCK_ADDR)        ? {susp_sel_reg, ilock_reg[6:0]} :
                                         8'h00;
    always_ff @(posedge CLK) begin
        if (RESET)
            rdata_reg <= 8'h00;
        else if (SP_RD)
            rdata_reg <= mode_hub ? rd_mux : 8'h00;
    end
    assign SP_RDATA = rdata_reg;

    // interrupt pin: general event or suspend level
    wire gen_int  = |(status_word & mask_reg);
    // port suspend intentionally unused here
    wire susp_low = ~HUB_CONFIGURED | HUB_SUSPENDED;
    wire pull_low = mode_hub &
                    (susp_sel_reg ? susp_low : gen_int);
    assign INT_N_O    = 1'b0;
    assign INT_N_OE_N = ~pull_low;

    wire unused_ok = PORT_SUSPENDED;
endmodule

// ===== design/hmic_pkg.sv
// Purpose: shared constants for the hub mode and interrupt control block
// Assumes: 20 MHz system clock, byte-wide serial register port
// Notes:   offsets are serial-port register addresses
package hmic_pkg;
    localparam logic [7:0] EVENT_STATUS_ADDR = 8'he8;
    localparam logic [7:0] EVENT_MASK_ADDR   = 8'he9;
    localparam logic [7:0] ILOCK_ADDR        = 8'he7;
    localparam logic [7:0] EVENT_STATUS_RST  = 8'h00;
    localparam logic [7:0] EVENT_MASK_RST    = 8'h00;
    // interlock register: bit 0 holds off the communication stage while HUB_CONNECT is low
    localparam int         ILOCK_CONNECT_BIT = 0;
    localparam logic [7:0] ILOCK_RST         = 8'h01;
    localparam int         EVENT_BITS        = 8;
    // reference clock select encodings, frequency in kHz
    localparam logic [1:0] REFSEL_38M4 = 2'h0;
    localparam logic [1:0] REFSEL_26M0 = 2'h1;
    localparam logic [1:0] REFSEL_19M2 = 2'h2;
    localparam logic [1:0] REFSEL_12M0 = 2'h3;
    localparam int         REF_KHZ_38M4 = 38400;
    localparam int         REF_KHZ_26M0 = 26000;
    localparam int         REF_KHZ_19M2 = 19200;
    localparam int         REF_KHZ_12M0 = 12000;

    typedef enum logic [1:0] {
        HMIC_STANDBY,
        HMIC_BYPASS,
        HMIC_HUB
    } hmic_mode_t;

    typedef enum logic [1:0] {
        HMIC_ST_IDLE,
        HMIC_ST_WAIT,
        HMIC_ST_COMM
    } hmic_stage_t;
endpackage

// ===== design/hmic_evt_if.sv
// Purpose: carries event sources and their latched status between modules
// Assumes: single clock domain
// Notes:   none
`timescale 1ns/1ps
interface hmic_evt_if #(parameter int N = 8);
    logic [N-1:0] cond;
    logic [N-1:0] clr;
    logic [N-1:0] status;
    modport ctrl (output cond, output clr, input status);
    modport latch (input cond, input clr, output status);
endinterface

// ===== design/hmic_event_latch.sv
// Purpose: per-bit latched, new-event-only status capture
// Assumes: cond synchronous to clk
// Notes:   set beats clear in the same cycle
`timescale 1ns/1ps
module hmic_event_latch
    import hmic_pkg::*;
#(
    parameter int N = EVENT_BITS
) (
    input  wire logic clk,   // system clock
    input  wire logic reset, // sync reset, high
    hmic_evt_if.latch evt    // conditions, clears, status
);
    logic [N-1:0] cond_prev_reg;
    logic [N-1:0] status_reg;

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_bit
            wire rise = evt.cond[i] & ~cond_prev_reg[i];
            always_ff @(posedge clk) begin
                if (reset) begin
                    cond_prev_reg[i] <= 1'b0;
                    status_reg[i]    <= 1'b0;
                end else begin
                    cond_prev_reg[i] <= evt.cond[i];
                    // held until cleared, even when cond drops
                    if (rise)
                        status_reg[i] <= 1'b1;
                    else if (evt.clr[i])
                        status_reg[i] <= 1'b0;
                end
            end
        end
    endgenerate

    assign evt.status = status_reg;
endmodule

// ===== bench/hmic_top_monitor.sv
// Purpose: port assertions for hub mode and interrupt control
// Assumes: one clock, sync reset high
// Notes:   bound from the bench top file
`timescale 1ns/1ps
module hmic_top_monitor (
    input wire logic       CLK,           // clock
    input wire logic       RESET,         // reset
    input wire logic       MODE_RESET_N,  // mode pin
    input wire logic       MODE_BYPASS_N, // mode pin
    input wire logic       HUB_CONNECT,   // connect
    input wire logic       REF_CLOCK_IN,  // ref clock
    input wire logic       SP_RD,         // read strobe
    input wire logic [7:0] SP_RDATA,      // read data
    input wire logic       INT_N_O,       // pin value
    input wire logic       MODE_STANDBY,  // standby
    input wire logic       MODE_BYPASS,   // bypass
    input wire logic       MODE_HUB,      // hub
    input wire logic       COMM_STAGE,    // stage
    input wire logic       REF_EDGE       // ref edge
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);
    a_standby_decode: assert property (
        MODE_STANDBY == !MODE_RESET_N) else $error("standby decode");
    a_bypass_decode: assert property (
        MODE_BYPASS == (MODE_RESET_N && !MODE_BYPASS_N))
        else $error("bypass decode");
    a_hub_decode: assert property (
        MODE_HUB == (MODE_RESET_N && MODE_BYPASS_N)) else $error("hub decode");
    a_ref_rise: assert property (
        !$past(RESET) |-> REF_EDGE == (REF_CLOCK_IN && !$past(REF_CLOCK_IN)))
        else $error("ref edge");
    a_comm_enter: assert property (
        (MODE_HUB && HUB_CONNECT) [*4] |=> COMM_STAGE) else $error("no comm");
    a_comm_leave: assert property (
        !MODE_HUB |=> !COMM_STAGE) else $error("comm outside hub");
    a_pin_drain: assert property (
        INT_N_O == 1'b0) else $error("pin driven high");
    a_read_refused: assert property (
        SP_RD && !MODE_HUB |=> SP_RDATA == 8'h00) else $error("read outside hub");
endmodule

// ===== bench/hmic_soc_model.sv
// Purpose: controller model driving mode pins and register port
// Assumes: one byte access per two cycles
// Notes:   released bus lines show the inverse of the last value
`timescale 1ns/1ps
module hmic_soc_model (
    input  wire logic clk,   // clock
    output logic      rst_n, // mode pin
    output logic      byp_n, // mode pin
    output logic      conn,  // connect
    output logic [1:0] rsel, // ref select
    output logic [7:0] addr, // address
    output logic [7:0] wdata,// write data
    output logic      wr,    // write strobe
    output logic      rd     // read strobe
);
    initial {rst_n, byp_n, conn, rsel, addr, wdata, wr, rd} = '0;
    task automatic mode(input logic r, input logic b);
        @(negedge clk);
        {rst_n, byp_n} <= {r, b};
        if (!(r && b)) conn <= 1'b0;
    endtask
    task automatic connect(input logic v);
        @(negedge clk);
        conn <= v && rst_n;
    endtask
    task automatic set_ref(input logic [1:0] s);
        @(negedge clk);
        rsel <= s;
    endtask
    // a status write here is how the pin is let go
    task automatic access(input logic w, input logic [7:0] a, d);
        @(negedge clk);
        {wr, rd, addr, wdata} <= {w, !w, a, d};
        @(negedge clk);
        {wr, rd, addr, wdata} <= {2'h0, ~a, ~d};
    endtask
endmodule

// ===== bench/hmic_top_tb.sv
// Purpose: self-checking bench for hub mode and interrupt control
// Assumes: partner model drives mode pins and register port
// Notes:   reference model tracks status, mask and pin level
`timescale 1ns/1ps
module hmic_top_tb;
    import hmic_pkg::*;
    logic CLK = 0, RESET = 1, REF_CLOCK_IN = 0, cfg = 0, sus = 0, psu = 0;
    logic [7:0] ec = 0, st = 0, mk = 0, prv = 0, rdata, addr, wdata;
    logic sel = 0, oe_n, comm, sby, byp, hub, rn, bn, con, wr, rd;
    logic [1:0] rsel, rlat;
    int bad_count = 0, n_tests = 0, cyc = 0, seed = 32'h0731, r;
    initial forever #25 CLK = ~CLK;
    hmic_soc_model soc (.clk(CLK), .rst_n(rn), .byp_n(bn), .conn(con),
        .rsel(rsel), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
    hmic_top dut (.CLK(CLK), .RESET(RESET), .MODE_RESET_N(rn),
        .MODE_BYPASS_N(bn), .HUB_CONNECT(con), .REF_SEL(rsel),
        .REF_CLOCK_IN(REF_CLOCK_IN), .HUB_CONFIGURED(cfg),
        .HUB_SUSPENDED(sus), .PORT_SUSPENDED(psu), .EVENT_COND(ec),
        .SP_ADDR(addr), .SP_WDATA(wdata), .SP_WR(wr), .SP_RD(rd),
        .SP_RDATA(rdata), .INT_N_O(), .INT_N_OE_N(oe_n),
        .MODE_STANDBY(sby), .MODE_BYPASS(byp), .MODE_HUB(hub),
        .COMM_STAGE(comm), .REF_SEL_LATCHED(rlat), .REF_EDGE());
    task automatic chk(input string nm, input logic [7:0] e, g);
        n_tests++;
        if (e !== g) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            bad_count++;
        end
    endtask
    task automatic complete_run();
        if (bad_count == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // reference model, updated on the same edge as the design
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (RESET || !(rn && bn)) begin
            {st, mk, sel} <= '0;
        end else begin
            st <= (st & ~((wr && addr == EVENT_STATUS_ADDR) ? wdata : 8'h00))
                | (ec & ~prv);
            if (wr && addr == EVENT_MASK_ADDR) mk <= wdata;
            if (wr && addr == ILOCK_ADDR) sel <= wdata[7];
        end
        prv <= ec;
    end
    always @(negedge CLK) begin
        REF_CLOCK_IN <= (cyc % 3) == 0;
        if (!RESET) chk("int_oe_n", {7'h0, !(rn && bn) || (sel ? cfg && !sus
            : ~|(st & mk))}, {7'h0, oe_n});
        if (cyc == 20000) begin
            bad_count++;
            complete_run();
        end
    end
    initial begin
        repeat (2) @(posedge CLK);
        @(negedge CLK) RESET <= 0;
        for (int i = 0; i < 4; i++) begin
            soc.mode(i[0], i[1]);
            soc.access(0, EVENT_STATUS_ADDR, 8'h00);
            chk("mode", {5'h0, !i[0], i == 1, i == 3}, {5'h0, sby, byp, hub});
            chk("rdata", 8'h00, rdata);
        end
        for (int i = 0; i < 4; i++) begin
            soc.set_ref(i[1:0]);
            soc.mode(0, 0);
            soc.mode(1, 1);
            repeat (2) @(negedge CLK);
            chk("ref_sel", {6'h0, i[1:0]}, {6'h0, rlat});
        end
        repeat (6) @(negedge CLK);
        chk("comm", 8'h00, {7'h0, comm});
        soc.access(1, ILOCK_ADDR, 8'h00);
        repeat (2) @(negedge CLK);
        chk("comm", 8'h01, {7'h0, comm});
        soc.mode(0, 0);
        soc.mode(1, 1);
        soc.connect(1);
        repeat (4) @(negedge CLK);
        chk("comm", 8'h01, {7'h0, comm});
        for (int k = 0; k < 300; k++) begin
            r = $random(seed);
            @(negedge CLK) ec <= r[7:0];
            if (k == 200) soc.access(1, ILOCK_ADDR, 8'h80);
            if (k > 200) {cfg, sus, psu} <= r[28:26];
            case (r[9:8])
                2'h0: soc.access(1, EVENT_STATUS_ADDR, r[17:10]);
                2'h1: soc.access(1, EVENT_MASK_ADDR, r[25:18]);
                2'h2: begin
                    soc.access(0, EVENT_STATUS_ADDR, 8'h00);
                    chk("status", st, rdata);
                end
                default: begin
                    soc.access(0, EVENT_MASK_ADDR, 8'h00);
                    chk("mask", mk, rdata);
                end
            endcase
        end
        soc.access(0, 8'h00, 8'h00);
        chk("unmapped", 8'h00, rdata);
        complete_run();
    end
endmodule
bind hmic_top hmic_top_monitor mon (.CLK(CLK), .RESET(RESET),
    .MODE_RESET_N(MODE_RESET_N), .MODE_BYPASS_N(MODE_BYPASS_N),
    .HUB_CONNECT(HUB_CONNECT), .REF_CLOCK_IN(REF_CLOCK_IN), .SP_RD(SP_RD),
    .SP_RDATA(SP_RDATA), .INT_N_O(INT_N_O), .MODE_STANDBY(MODE_STANDBY),
    .MODE_BYPASS(MODE_BYPASS), .MODE_HUB(MODE_HUB),
    .COMM_STAGE(COMM_STAGE), .REF_EDGE(REF_EDGE));
